//--- rtl/wat_pkg.sv
package wat_pkg;
	// ==========================================================
	// Register map
	localparam logic [31:0] WAT_BASE_ADDR      = 32'h0000_CC80;
	localparam logic [4:0]  WAT_OFS_CONTROL    = 5'h00;
	localparam logic [4:0]  WAT_OFS_SECONDS    = 5'h04;
	localparam logic [4:0]  WAT_OFS_COMPARE    = 5'h08;
	localparam logic [4:0]  WAT_OFS_PRESCALER  = 5'h0C;
	localparam logic [4:0]  WAT_OFS_FRACTION   = 5'h10;
	localparam logic [4:0]  WAT_OFS_SHORT_CTL  = 5'h14;
	localparam logic [4:0]  WAT_OFS_SHORT_CNT  = 5'h18;
	localparam logic [31:0] WAT_WINDOW_MASK    = 32'hFFFF_FFE0;

	// ==========================================================
	// Control fields
	localparam int          WAT_BIT_RUN        = 0;
	localparam int          WAT_BIT_GPO        = 5;
	localparam int          WAT_BIT_WAKE_EN    = 6;

	// ==========================================================
	// Widths and reset values
	localparam int          WAT_PRESC_W        = 15;
	localparam int          WAT_COUNT_W        = 28;
	localparam logic [14:0] WAT_PRESC_RESET    = 15'h0001;
	localparam logic [14:0] WAT_PRESC_ZERO     = 15'h0000;
	localparam logic [14:0] WAT_PRESC_WRAP     = 15'h7FFF;
	localparam logic [27:0] WAT_SECONDS_RESET  = 28'h000_0000;
	localparam logic [27:0] WAT_COMPARE_RESET  = 28'h0FF_FFFF;
	localparam logic [31:0] WAT_READ_ZERO      = 32'h0000_0000;

	// ==========================================================
	// Bus slave states
	typedef enum logic [1:0] {
		WAT_BUS_IDLE,
		WAT_BUS_READ,
		WAT_BUS_WRITE
	} wat_bus_state_t;
endpackage : wat_pkg

//--- rtl/wat_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
module wat_sync_edge
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Asynchronous level in
	input  wire logic async_in,
	// Synchronised level and rising-edge pulse
	output var  logic level_q,
	output var  logic rise_q
);
	logic meta_q;
	logic sync_q;

	// ==========================================================
	// Two-stage synchroniser; only sync_q is looked at
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_q  <= 1'b0;
			sync_q  <= 1'b0;
			level_q <= 1'b0;
			rise_q  <= 1'b0;
		end
		else
		begin
			meta_q  <= async_in;
			sync_q  <= meta_q;
			level_q <= sync_q;
			rise_q  <= sync_q & ~level_q;
		end
	end
endmodule // wat_sync_edge
`default_nettype wire

//--- rtl/wat_core.sv
// What this block does
// - Wake event output is gated by wake enable bit 6; disabling clears its pending state.
// - Wake enable also gates decoding of alarm wake events.
// - Control bit 5 drives the battery general-purpose output level directly.
// - Run enable bit 0 starts and stops seconds counter and prescaler.
// - Seconds counter holds while stopped and resumes from held value.
// - While stopped the prescaler is forced to zero, lowest-power state.
// - Seconds counter bits 27:0 increment once per second; reads return it.
// - Seconds writes may take up to one second to appear.
// - Seconds and compare accesses work whether running or stopped.
// - Counter at or above compare asserts alarm interrupt, and wake event while wake enable is set.
// - Prescaler register is read-only, bits 14:0 return the live value.
// - Registers decode at base address plus offsets 00h through 18h.
// - Prescaler counts slow clock, wrap from 7FFFh gives the one-second tick.
// - Writes take effect on the next bus clock edge, well within two slow clock cycles.
`timescale 1ns/1ps
`default_nettype none
module wat_core
	import wat_pkg::*;
#(
	parameter int          PRESC_W   = wat_pkg::WAT_PRESC_W,
	parameter int          COUNT_W   = wat_pkg::WAT_COUNT_W,
	parameter logic [31:0] BASE_ADDR = wat_pkg::WAT_BASE_ADDR
)
(
	// Clock and battery-rail reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Controller internal bus
	input  wire logic [31:0] bus_addr,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	input  wire logic [31:0] bus_wdata,
	output var  logic [31:0] bus_rdata,
	output var  logic        bus_ack,
	// Slow crystal clock pin
	input  wire logic        slow_crystal_clock,
	// Block outputs
	output var  logic        alarm_irq,
	output var  logic        wake_event,
	output var  logic        battery_gp_output
);
	import wat_pkg::*;

	// ==========================================================
	// Elaboration checks
	if (PRESC_W != WAT_PRESC_W)
	begin : g_bad_presc
		$error("prescaler width must be 15");
	end
	if (COUNT_W != WAT_COUNT_W)
	begin : g_bad_count
		$error("seconds counter width must be 28");
	end
	// The decode compares whole words against the window, so the base must be window aligned
	if ((BASE_ADDR & ~WAT_WINDOW_MASK) != WAT_READ_ZERO)
	begin : g_bad_base
		$error("base address must be aligned to the register window");
	end

	// ==========================================================
	// Decode helpers
	function automatic logic in_window(input logic [31:0] a);
		in_window = ((a & WAT_WINDOW_MASK) == BASE_ADDR) && (a[4:0] <= WAT_OFS_SHORT_CNT)
			&& (a[1:0] == 2'b00);
	endfunction

	function automatic logic is_reg(input logic [31:0] a, input logic [4:0] ofs);
		is_reg = in_window(a) && (a[4:0] == ofs);
	endfunction

	// ==========================================================
	// State
	logic                 run_q;
	logic                 gpo_q;
	logic                 wake_en_q;
	logic [14:0]          presc_q;
	logic [27:0]          seconds_q;
	logic [27:0]          compare_q;
	logic                 wake_pend_q;
	wat_bus_state_t       bus_next;
	logic                 slow_rise;
	logic                 tick;
	logic                 alarm_hit;
	logic                 wr_ctl;
	logic                 wr_sec;
	logic                 wr_cmp;

	// ==========================================================
	// Read mux
	// reserved bits and unbuilt registers read zero
	function automatic logic [31:0] read_word(input logic [4:0] ofs);
		read_word = WAT_READ_ZERO;
		case (ofs)
			WAT_OFS_CONTROL:
			begin
				read_word[WAT_BIT_RUN]     = run_q;
				read_word[WAT_BIT_GPO]     = gpo_q;
				read_word[WAT_BIT_WAKE_EN] = wake_en_q;
			end
			WAT_OFS_SECONDS:
				read_word[COUNT_W-1:0] = seconds_q;
			WAT_OFS_COMPARE:
				read_word[COUNT_W-1:0] = compare_q;
			WAT_OFS_PRESCALER:
				read_word[PRESC_W-1:0] = presc_q;
			default:
				read_word = WAT_READ_ZERO;
		endcase
	endfunction

	// ==========================================================
	// Slow clock sampling
	wat_sync_edge u_slow
	(
		.clk      (clk),
		.arst_n   (arst_n),
		.async_in (slow_crystal_clock),
		.level_q  (),
		.rise_q   (slow_rise)
	);

	assign tick      = run_q && slow_rise && (presc_q == WAT_PRESC_WRAP);
	assign alarm_hit = (seconds_q >= compare_q);

	assign wr_ctl = bus_wr && is_reg(bus_addr, WAT_OFS_CONTROL);
	assign wr_sec = bus_wr && is_reg(bus_addr, WAT_OFS_SECONDS);
	assign wr_cmp = bus_wr && is_reg(bus_addr, WAT_OFS_COMPARE);

	// ==========================================================
	// Control register
	// battery reset only
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			run_q     <= 1'b0;
			gpo_q     <= 1'b0;
			wake_en_q <= 1'b0;
		end
		// applied on the bus edge, well inside two slow cycles
		else if (wr_ctl)
		begin
			// only the three defined bits are stored
			run_q     <= bus_wdata[WAT_BIT_RUN];
			gpo_q     <= bus_wdata[WAT_BIT_GPO];
			wake_en_q <= bus_wdata[WAT_BIT_WAKE_EN];
		end
	end

	// ==========================================================
	// Prescaler
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			presc_q <= WAT_PRESC_RESET;
		else if (!run_q)
			presc_q <= WAT_PRESC_ZERO;
		else if (slow_rise)
			presc_q <= presc_q + 15'h0001;
	end

	// ==========================================================
	// Seconds counter
	// A write in the same cycle as a tick wins; the tick is lost, not the write
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			seconds_q <= WAT_SECONDS_RESET;
		// write accepted whether running or not
		else if (wr_sec)
			// visible at once, well within the allowed second
			seconds_q <= bus_wdata[27:0];
		else if (tick)
			seconds_q <= seconds_q + 28'h000_0001;
		// otherwise holds, so resume is from the held value
	end

	// ==========================================================
	// Compare register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			compare_q <= WAT_COMPARE_RESET;
		else if (wr_cmp)
			compare_q <= bus_wdata[27:0];
	end

	// ==========================================================
	// Outputs
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			alarm_irq <= 1'b0;
		else
			alarm_irq <= alarm_hit;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			wake_pend_q <= 1'b0;
		else if (!wake_en_q)
			wake_pend_q <= 1'b0;
		// decoded only while wake enable is set
		else if (alarm_hit)
			wake_pend_q <= 1'b1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			wake_event <= 1'b0;
		else
			wake_event <= wake_en_q && (wake_pend_q || alarm_hit);
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			battery_gp_output <= 1'b0;
		else
			battery_gp_output <= gpo_q;
	end

	// ==========================================================
	// Bus slave: one-cycle answer for any access inside the window
	// A read with a write in the same cycle is classed as a read; the write still lands
	always_comb
	begin
		bus_next = WAT_BUS_IDLE;
		case (1'b1)
			bus_rd && in_window(bus_addr):
				bus_next = WAT_BUS_READ;
			bus_wr && in_window(bus_addr):
				bus_next = WAT_BUS_WRITE;
			default:
				bus_next = WAT_BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			bus_ack <= 1'b0;
		else
			bus_ack <= (bus_next != WAT_BUS_IDLE);
	end

	// Read data stands only with the answer, so a stale word never lingers on the bus
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			bus_rdata <= WAT_READ_ZERO;
		else if (bus_next == WAT_BUS_READ)
			bus_rdata <= read_word(bus_addr[4:0]);
		else
			bus_rdata <= WAT_READ_ZERO;
	end
endmodule // wat_core
`default_nettype wire

//--- test/wat_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module wat_core_monitor
	import wat_pkg::*;
#(
	parameter logic [31:0] BASE_ADDR = wat_pkg::WAT_BASE_ADDR
)
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        arst_n,
	// Bus
	input wire logic [31:0] bus_addr,
	input wire logic        bus_wr,
	input wire logic        bus_rd,
	input wire logic [31:0] bus_wdata,
	input wire logic [31:0] bus_rdata,
	input wire logic        bus_ack,
	// Pins
	input wire logic        slow_crystal_clock,
	input wire logic        alarm_irq,
	input wire logic        wake_event,
	input wire logic        battery_gp_output
);
	// ==========================================================
	// Shadow of the control bits, kept from bus writes only
	logic       req;
	logic       rd_q;
	logic [4:0] ofs_q;
	logic [6:0] ctl_h;
	assign req = (bus_rd | bus_wr) && ((bus_addr & WAT_WINDOW_MASK) == BASE_ADDR)
		&& (bus_addr[1:0] == 2'h0) && (bus_addr[4:0] <= 5'h18);
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			ctl_h <= 7'h00;
		else if (req && bus_wr && bus_addr[4:0] == 5'h00)
			ctl_h <= bus_wdata[6:0] & 7'h61;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rd_q <= 1'b0;
		else
			rd_q <= req && bus_rd;
	end
	always_ff @(posedge clk)
	begin
		ofs_q <= bus_addr[4:0];
	end
	// ==========================================================
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_req;
		req;
	endsequence
	chk_ack_on_req: assert property (s_req |=> bus_ack)
		else $error("no ack after request");
	chk_ack_cause: assert property (bus_ack |-> $past(req))
		else $error("ack without request");
	chk_rdata_idle: assert property (!bus_ack |-> bus_rdata == 32'h0)
		else $error("read data outside ack");
	chk_ctl_readback: assert property (rd_q && ofs_q == 5'h00 |-> bus_rdata == {25'h0, ctl_h})
		else $error("control readback wrong");
	chk_count_rsvd: assert property (rd_q && ofs_q inside {5'h04, 5'h08} |-> bus_rdata[31:28] == 4'h0)
		else $error("count reserved bits set");
	chk_spare_zero: assert property (rd_q && ofs_q >= 5'h0C |-> bus_rdata[31:15] == 17'h0)
		else $error("spare bits set");
	chk_gpo_follows: assert property (ctl_h == $past(ctl_h) && ctl_h == $past(ctl_h, 2)
		|-> battery_gp_output == ctl_h[5])
		else $error("output level differs from control");
	chk_wake_gated: assert property (!ctl_h[6] && !$past(ctl_h[6]) && !$past(ctl_h[6], 2)
		|-> !wake_event)
		else $error("wake event while disabled");
	chk_presc_stopped: assert property (rd_q && ofs_q == 5'h0C && !$past(ctl_h[0])
		&& !$past(ctl_h[0], 2) && $past(arst_n, 2) |-> bus_rdata == 32'h0)
		else $error("prescaler not zero while stopped");
endmodule // wat_core_monitor
`default_nettype wire

//--- test/wat_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module wat_core_bench;
	import wat_pkg::*;
	// ==========================================================
	// Signals and model state
	logic        clk = 1'b0, arst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, sck = 1'b0;
	logic [31:0] bus_addr = 32'h0, bus_wdata = 32'h0, bus_rdata, rdat;
	logic        bus_ack, alarm_irq, wake_event, battery_gp_output, ok;
	logic [27:0] m_sec = 28'h0, m_cmp = 28'h0FF_FFFF;
	logic [6:0]  m_ctl = 7'h00;
	logic        m_pend = 1'b0;
	int          n_fail = 0, n_compared = 0;
	always #25 clk = ~clk;
	wat_core wat_core_i (.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
		.slow_crystal_clock(sck), .alarm_irq(alarm_irq), .wake_event(wake_event),
		.battery_gp_output(battery_gp_output));
	// ==========================================================
	// Bus and pin tasks; ack arrives one cycle after the strobe
	task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_wr <= w;
		bus_rd <= !w;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_wr <= 1'b0;
		bus_rd <= 1'b0;
		#1 ok = bus_ack;
		rdat = bus_rdata;
	endtask
	task automatic wr(input logic [4:0] o, input logic [31:0] d);
		acc(1'b1, WAT_BASE_ADDR + 32'(o), d);
		if (o == 5'h00) m_ctl = d[6:0] & 7'h61;
		if (o == 5'h04) m_sec = d[27:0];
		if (o == 5'h08) m_cmp = d[27:0];
	endtask
	task automatic rd(input logic [4:0] o, input logic [31:0] e);
		acc(1'b0, WAT_BASE_ADDR + 32'(o), 32'h0);
		`CHK({ok, rdat}, {1'b1, e})
	endtask
	// Pending wake is only dropped by clearing the enable
	task automatic outs;
		repeat (4) @(posedge clk);
		#1 if (!m_ctl[6]) m_pend = 1'b0; else if (m_sec >= m_cmp) m_pend = 1'b1;
		`CHK({alarm_irq, wake_event, battery_gp_output},
			{m_sec >= m_cmp, m_ctl[6] & (m_pend | (m_sec >= m_cmp)), m_ctl[5]})
	endtask
	task automatic rises(input int n);
		repeat (n)
		begin
			@(posedge clk) sck <= 1'b1;
			@(posedge clk) sck <= 1'b0;
		end
		repeat (6) @(posedge clk);
	endtask
	task finish_test;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial
	begin
		void'($urandom(32'h707e));
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		rd(5'h00, 32'h0);
		rd(5'h08, 32'h0FF_FFFF);
		rd(5'h0C, 32'h0);
		for (int o = 16; o <= 24; o += 4) rd(5'(o), 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			acc(1'b0, WAT_BASE_ADDR + ((i == 2) ? 32'h2 : 32'h1C + 32'(i) * 4), 32'h0);
			`CHK(ok, 1'b0)
		end
		outs;
		$display("reset test done");
		for (int i = 0; i < 4; i++)
		begin
			wr(5'h00, ($urandom & 32'hFFFF_FF9E) | (32'(i) << 5));
			rd(5'h00, 32'(m_ctl));
			outs;
		end
		wr(5'h0C, 32'hFFFF_FFFF);
		wr(5'h10, $urandom);
		rd(5'h0C, 32'h0);
		rd(5'h10, 32'h0);
		$display("control test done");
		wr(5'h04, $urandom | 32'hF000_0000 & 32'hF7FF_FFFF);
		rd(5'h04, 32'(m_sec));
		wr(5'h08, 32'(m_sec));
		outs;
		wr(5'h08, 32'(m_sec) + 32'h1);
		outs;
		wr(5'h00, 32'h20);
		outs;
		wr(5'h00, 32'h60);
		outs;
		wr(5'h08, 32'(m_sec) - 32'h1);
		outs;
		$display("alarm test done");
		wr(5'h00, 32'h61);
		rises(100);
		rd(5'h0C, 32'h64);
		rd(5'h04, 32'(m_sec));
		wr(5'h00, 32'h60);
		rises(20);
		rd(5'h0C, 32'h0);
		rd(5'h04, 32'(m_sec));
		wr(5'h08, 32'(m_sec) + 32'h1);
		wr(5'h00, 32'h61);
		outs;
		rises(32768);
		m_sec = m_sec + 28'h1;
		rd(5'h04, 32'(m_sec));
		rd(5'h0C, 32'h0);
		outs;
		wr(5'h00, 32'h60);
		rises(9);
		wr(5'h00, 32'h61);
		rises(3);
		rd(5'h0C, 32'h3);
		rd(5'h04, 32'(m_sec));
		$display("run test done");
		finish_test;
	end
	initial
	begin
		repeat (80000) @(posedge clk);
		n_fail++;
		finish_test;
	end
endmodule // wat_core_bench
bind wat_core wat_core_monitor #(.BASE_ADDR(BASE_ADDR)) wat_core_monitor_i (.clk(clk),
	.arst_n(arst_n), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
	.slow_crystal_clock(slow_crystal_clock), .alarm_irq(alarm_irq),
	.wake_event(wake_event), .battery_gp_output(battery_gp_output));
`default_nettype wire
